// [include/mct_regs.svh]
// Register offsets, reset values and field positions of the match/capture timer
`ifndef MCT_REGS_SVH
`define MCT_REGS_SVH

`define MCT_CTRL_OFS      8'h00
`define MCT_COUNT_OFS     8'h04
`define MCT_PRE_LIM_OFS   8'h08
`define MCT_PRE_CNT_OFS   8'h0c
`define MCT_MATCH_CTL_OFS 8'h10
`define MCT_CAP_CTL_OFS   8'h14
`define MCT_EXT_MATCH_OFS 8'h18
`define MCT_INT_STS_OFS   8'h1c
`define MCT_INT_MASK_OFS  8'h20
`define MCT_PIN_SEL_OFS   8'h24
`define MCT_MATCH0_OFS    8'h28
`define MCT_CAP0_OFS      8'h38

`define MCT_CTRL_RST      32'h0000_0000
`define MCT_PIN_SEL_RST   32'h00ff_0249
`define MCT_ZERO_RST      32'h0000_0000

`define MCT_PIN_AND_BIT   2
`define MCT_PIN_OUT_BIT   16
`define MCT_EXT_ACT_BIT   4
`define MCT_STS_CAP_BIT   4

`define MCT_RESP_OKAY     2'b00
`define MCT_RESP_SLVERR   2'b10

`endif

// [include/mct_pkg.sv]
// Types shared by the match/capture timer
package mct_pkg;
  typedef enum logic [1:0] {
    MCT_MODE_TIMER = 2'b00,
    MCT_MODE_RISE  = 2'b01,
    MCT_MODE_FALL  = 2'b10,
    MCT_MODE_BOTH  = 2'b11
  } mct_mode_type;

  typedef enum logic [1:0] {
    MCT_ACT_NONE   = 2'b00,
    MCT_ACT_LOW    = 2'b01,
    MCT_ACT_HIGH   = 2'b10,
    MCT_ACT_TOGGLE = 2'b11
  } mct_act_type;

  typedef struct packed {
    logic [25:0]  rsvd;
    logic [1:0]   evsel;
    mct_mode_type mode;
    logic         crst;
    logic         en;
  } mct_ctrl_type;

  typedef struct packed {
    logic int_en;
    logic rst;
    logic stop;
  } mct_mctl_type;

  typedef struct packed {
    logic int_en;
    logic fall;
    logic rise;
  } mct_cctl_type;
endpackage

// [rtl/mct_timer.sv]
// Match/capture timer/counter with AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "mct_regs.svh"

module mct_timer
  import mct_pkg::*;
#(
  parameter bit WIDE = 1'b1
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic        S_AXI_AWVALID,
  output wire logic        S_AXI_AWREADY,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output wire logic        S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  input  wire logic        S_AXI_ARVALID,
  output wire logic        S_AXI_ARREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  input  wire logic [7:0]  CAP_PIN,
  output logic [7:0]       MATCH_PIN,
  output wire logic        IRQ
);
  localparam int CNT_W = WIDE ? 32 : 16;
  localparam int NCAP  = WIDE ? 4 : 3;

  mct_ctrl_type     ctrl;
  logic [CNT_W-1:0] tc;
  logic [CNT_W-1:0] pr;
  logic [CNT_W-1:0] pc;
  logic [CNT_W-1:0] mr [4];
  logic [CNT_W-1:0] cr [4];
  logic [11:0]      mctl;
  logic [11:0]      cctl;
  logic [11:0]      ext;
  logic [7:0]       sts;
  logic [7:0]       mask;
  logic [23:0]      pinsel;

  logic [7:0]       cap_s1;
  logic [7:0]       cap_s2;
  logic [3:0]       cap_lvl;
  logic [3:0]       cap_prev;
  logic [3:0]       cap_rise;
  logic [3:0]       cap_fall;
  logic [3:0]       cap_evt;
  logic [3:0]       match_hit;
  logic             tick;
  logic             term;
  logic             any_rst;
  logic             any_stop;

  logic             aw_held;
  logic             w_held;
  logic [7:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             do_wr;
  logic             do_rd;
  logic [31:0]      rd_val;
  logic             rd_ok;
  logic             wr_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= (`MCT_CAP0_OFS + 8'h0c));
  endfunction

  // AXI4-Lite slave; address and data may come in either order
  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY  = !w_held;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign do_wr         = aw_held && w_held && !S_AXI_BVALID;
  assign do_rd         = S_AXI_ARVALID && !S_AXI_RVALID;
  assign wr_ok         = known(awaddr_q) && (awaddr_q < `MCT_CAP0_OFS);
  assign rd_ok         = known(S_AXI_ARADDR);

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `MCT_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_held) begin
        aw_held  <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held) begin
        w_held  <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? `MCT_RESP_OKAY : `MCT_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (S_AXI_ARADDR[7:2])
      6'h00:   rd_val = ctrl;
      6'h01:   rd_val = 32'(tc);
      6'h02:   rd_val = 32'(pr);
      6'h03:   rd_val = 32'(pc);
      6'h04:   rd_val = {20'h00000, mctl};
      6'h05:   rd_val = {20'h00000, cctl};
      6'h06:   rd_val = {20'h00000, ext};
      6'h07:   rd_val = {24'h000000, sts};
      6'h08:   rd_val = {24'h000000, mask};
      6'h09:   rd_val = {8'h00, pinsel};
      6'h0a:   rd_val = 32'(mr[0]);
      6'h0b:   rd_val = 32'(mr[1]);
      6'h0c:   rd_val = 32'(mr[2]);
      6'h0d:   rd_val = 32'(mr[3]);
      6'h0e:   rd_val = 32'(cr[0]);
      6'h0f:   rd_val = 32'(cr[1]);
      6'h10:   rd_val = 32'(cr[2]);
      6'h11:   rd_val = 32'(cr[3]);
      default: rd_val = 32'h0000_0000;
    endcase
    if (!rd_ok) begin
      rd_val = 32'h0000_0000;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `MCT_RESP_OKAY;
    end else if (do_rd) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_val;
      S_AXI_RRESP  <= rd_ok ? `MCT_RESP_OKAY : `MCT_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Configuration registers; a stopping match clears the run bit
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl   <= `MCT_CTRL_RST;
      pr     <= '0;
      mctl   <= 12'h000;
      cctl   <= 12'h000;
      mask   <= 8'h00;
      pinsel <= 24'(`MCT_PIN_SEL_RST);
      for (int i = 0; i < 4; i++) begin
        mr[i] <= '0;
      end
    end else begin
      if (do_wr) begin
        unique case (awaddr_q)
          `MCT_CTRL_OFS:      ctrl   <= merge(ctrl, wdata_q, wstrb_q);
          `MCT_PRE_LIM_OFS:   pr     <= CNT_W'(merge(32'(pr), wdata_q, wstrb_q));
          `MCT_MATCH_CTL_OFS: mctl   <= 12'(merge({20'h0, mctl}, wdata_q, wstrb_q));
          `MCT_CAP_CTL_OFS:   cctl   <= 12'(merge({20'h0, cctl}, wdata_q, wstrb_q));
          `MCT_INT_MASK_OFS:  mask   <= 8'(merge({24'h0, mask}, wdata_q, wstrb_q));
          `MCT_PIN_SEL_OFS:   pinsel <= 24'(merge({8'h0, pinsel}, wdata_q, wstrb_q));
          default: begin
            for (int i = 0; i < 4; i++) begin
              if (awaddr_q == `MCT_MATCH0_OFS + 8'(4 * i)) begin
                mr[i] <= CNT_W'(merge(32'(mr[i]), wdata_q, wstrb_q));
              end
            end
          end
        endcase
      end
      if (any_stop) begin
        ctrl.en <= 1'b0;
      end
    end
  end

  // Two flops per pin before any logic looks at it
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cap_s1   <= 8'h00;
      cap_s2   <= 8'h00;
      cap_prev <= 4'h0;
    end else begin
      cap_s1   <= CAP_PIN;
      cap_s2   <= cap_s1;
      cap_prev <= cap_lvl;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chan
      logic [1:0]   pins;
      logic [1:0]   sel;
      mct_cctl_type cc;
      mct_mctl_type mc;
      assign pins = cap_s2[2*gi +: 2];
      assign sel  = pinsel[3*gi +: 2];
      assign cc   = mct_cctl_type'(cctl[3*gi +: 3]);
      assign mc   = mct_mctl_type'(mctl[3*gi +: 3]);
      // AND ignores unselected pins; an empty selection reads low
      assign cap_lvl[gi] = pinsel[3*gi + `MCT_PIN_AND_BIT]
                         ? (|sel && &(pins | ~sel))
                         : |(pins & sel);
      assign cap_rise[gi] = cap_lvl[gi] && !cap_prev[gi];
      assign cap_fall[gi] = !cap_lvl[gi] && cap_prev[gi];
      // Capture on channels below NCAP works whether or not this channel also feeds the counter
      assign cap_evt[gi] = (gi < NCAP) &&
                           ((cap_rise[gi] && cc.rise) || (cap_fall[gi] && cc.fall));
      assign match_hit[gi] = term && (tc == mr[gi]);

      always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
          cr[gi] <= '0;
        end else if (cap_evt[gi]) begin
          cr[gi] <= tc;
        end
      end
    end
  endgenerate

  always_comb begin
    any_rst  = 1'b0;
    any_stop = 1'b0;
    for (int i = 0; i < 4; i++) begin
      any_rst  = any_rst  | (match_hit[i] & mctl[3*i + 1]);
      any_stop = any_stop | (match_hit[i] & mctl[3*i]);
    end
  end

  // Edge mode needs the source pulse to span one clock, else it is missed
  always_comb begin
    unique case (ctrl.mode)
      MCT_MODE_TIMER: tick = 1'b1;
      MCT_MODE_RISE:  tick = cap_rise[ctrl.evsel];
      MCT_MODE_FALL:  tick = cap_fall[ctrl.evsel];
      MCT_MODE_BOTH:  tick = cap_rise[ctrl.evsel] | cap_fall[ctrl.evsel];
    endcase
  end

  assign term = ctrl.en && !ctrl.crst && tick && (pc == pr);

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tc <= '0;
      pc <= '0;
    end else if (ctrl.crst) begin
      tc <= '0;
      pc <= '0;
    end else if (do_wr && awaddr_q == `MCT_COUNT_OFS) begin
      tc <= CNT_W'(merge(32'(tc), wdata_q, wstrb_q));
    end else if (do_wr && awaddr_q == `MCT_PRE_CNT_OFS) begin
      pc <= CNT_W'(merge(32'(pc), wdata_q, wstrb_q));
    end else if (term) begin
      pc <= '0;
      // Unless a reset match also hits, a stopping match holds the matched value rather than stepping past it
      tc <= any_rst ? '0 : (any_stop ? tc : tc + CNT_W'(1));
    end else if (ctrl.en && tick) begin
      pc <= pc + CNT_W'(1);
    end
  end

  // Match outputs; software may also preset the levels
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ext       <= 12'h000;
      MATCH_PIN <= 8'h00;
    end else begin
      if (do_wr && awaddr_q == `MCT_EXT_MATCH_OFS) begin
        ext <= 12'(merge({20'h0, ext}, wdata_q, wstrb_q));
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (match_hit[i]) begin
            unique case (mct_act_type'(ext[`MCT_EXT_ACT_BIT + 2*i +: 2]))
              MCT_ACT_NONE:   ext[i] <= ext[i];
              MCT_ACT_LOW:    ext[i] <= 1'b0;
              MCT_ACT_HIGH:   ext[i] <= 1'b1;
              MCT_ACT_TOGGLE: ext[i] <= !ext[i];
            endcase
          end
        end
      end
      for (int p = 0; p < 8; p++) begin
        MATCH_PIN[p] <= ext[p/2] & pinsel[`MCT_PIN_OUT_BIT + p];
      end
    end
  end

  // Sticky flags, cleared by reading; a new event beats the clear
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sts <= 8'h00;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (match_hit[i] && mctl[3*i + 2]) begin
          sts[i] <= 1'b1;
        end else if (do_rd && S_AXI_ARADDR == `MCT_INT_STS_OFS) begin
          sts[i] <= 1'b0;
        end
        if (cap_evt[i] && cctl[3*i + 2]) begin
          sts[`MCT_STS_CAP_BIT + i] <= 1'b1;
        end else if (do_rd && S_AXI_ARADDR == `MCT_INT_STS_OFS) begin
          sts[`MCT_STS_CAP_BIT + i] <= 1'b0;
        end
      end
    end
  end

  assign IRQ = |(sts & mask);
endmodule

// [tb/mct_timer_properties.sv]
// Bus handshake, reset and interrupt properties of the match/capture timer
`timescale 1ns/1ns
module mct_timer_chk (
  input wire logic        CORE_CLK,
  input wire logic        RSTN,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic [7:0]  MATCH_PIN,
  input wire logic        IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  a_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> ##1 S_AXI_BVALID) else $error("write response missing");
  a_b_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  a_b_blocks: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("new write taken before response");
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read response missing");
  a_r_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  a_r_blocks: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while response pending");
  a_err_zero: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'b10 |-> S_AXI_RDATA == 32'h0)
    else $error("refused read returned data");
  // Reset must be watched while it is asserted, so no disable here
  a_reset_quiet: assert property (disable iff (1'b0)
    !RSTN |-> !S_AXI_BVALID && !S_AXI_RVALID && MATCH_PIN == 8'h00 && !IRQ)
    else $error("outputs active in reset");
  a_irq_sticky: assert property ($fell(IRQ) |-> S_AXI_RVALID || S_AXI_BVALID ||
    $past(S_AXI_RVALID) || $past(S_AXI_BVALID)) else $error("interrupt fell without access");

  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_refused: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'b10);
  c_irq: cover property ($rose(IRQ));
endmodule

bind mct_timer mct_timer_chk u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .MATCH_PIN(MATCH_PIN), .IRQ(IRQ));

// [tb/mct_pin_model.sv]
// Outside event and capture source feeding the capture pins
`timescale 1ns/1ns
module mct_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] want,
  output logic      [7:0] cap_pin
);
  // Levels move only on clock edges, so no pulse is shorter than a period
  always @(posedge clk) begin
    cap_pin <= want;
  end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the match/capture timer
`timescale 1ns/1ns
`include "mct_regs.svh"
module testbench;
  logic        core_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, want;
  logic [31:0] wdata, rd, rd_n;
  logic [1:0]  resp;
  wire logic   awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0]  cap_pin, match_pin;
  wire logic [31:0] rdata_n;
  int          miscompares, check_count;

  mct_timer #(.WIDE(1'b1)) DUT (.CORE_CLK(core_clk), .RSTN(rstn),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .CAP_PIN(cap_pin), .MATCH_PIN(match_pin), .IRQ(irq));
  // Narrow variant shares the bus; its handshake timing matches the wide one
  mct_timer #(.WIDE(1'b0)) DUT_NARROW (.CORE_CLK(core_clk), .RSTN(rstn),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_BVALID(), .S_AXI_BREADY(bready), .S_AXI_BRESP(),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(), .S_AXI_ARADDR(araddr),
    .S_AXI_RVALID(), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata_n), .S_AXI_RRESP(),
    .CAP_PIN(cap_pin), .MATCH_PIN(), .IRQ());
  mct_pin_model u_pins (.clk(core_clk), .want(want), .cap_pin(cap_pin));

  task automatic close_out;
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Response ready rises with the request and stays up, so calls chain cleanly
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
  endtask

  task automatic rdr(input logic [7:0] a);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rd_n = rdata_n;
    resp = rresp;
  endtask

  task automatic pulse(input int p);
    want[p] <= 1'b1;
    repeat (2) @(posedge core_clk);
    want[p] <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic t_reset_values;
    rdr(`MCT_CTRL_OFS);
    chk("ctrl", `MCT_CTRL_RST, rd);
    rdr(`MCT_PIN_SEL_OFS);
    chk("pin_sel", `MCT_PIN_SEL_RST, rd);
    rdr(8'h48);
    chk("unmapped resp", 32'(`MCT_RESP_SLVERR), 32'(resp));
    chk("unmapped data", 32'h0, rd);
    wr(`MCT_CAP0_OFS, 32'h1234);
    chk("capture write resp", 32'(`MCT_RESP_SLVERR), 32'(resp));
    rdr(`MCT_CAP0_OFS);
    chk("capture untouched", 32'h0, rd);
  endtask

  task automatic t_reset_on_match;
    int n;
    wr(`MCT_PRE_LIM_OFS, 32'h1);
    wr(`MCT_MATCH0_OFS, 32'h5);
    wr(`MCT_MATCH_CTL_OFS, 32'h6);
    wr(`MCT_EXT_MATCH_OFS, 32'h30);
    wr(`MCT_INT_MASK_OFS, 32'h1);
    wr(`MCT_CTRL_OFS, 32'h1);
    n = 0;
    while (!irq) begin
      @(posedge core_clk);
      n++;
    end
    // Stop at once so the next match cannot refill the status
    wr(`MCT_CTRL_OFS, 32'h0);
    chk("match delay", 32'h1, 32'(n >= 10 && n <= 13));
    chk("toggled pins", 32'h3, 32'(match_pin));
    rdr(`MCT_COUNT_OFS);
    chk("count wrapped", 32'h1, 32'(rd < 32'h2));
    rdr(`MCT_INT_STS_OFS);
    chk("match flag", 32'h1, rd);
    @(posedge core_clk);
    chk("irq cleared", 32'h0, 32'(irq));
  endtask

  task automatic t_stop_on_match;
    wr(`MCT_PRE_LIM_OFS, 32'h0);
    wr(`MCT_COUNT_OFS, 32'h0);
    wr(`MCT_PRE_CNT_OFS, 32'h0);
    wr(`MCT_MATCH0_OFS + 8'h04, 32'h3);
    wr(`MCT_MATCH_CTL_OFS, 32'h28);
    wr(`MCT_EXT_MATCH_OFS, 32'h80);
    wr(`MCT_INT_MASK_OFS, 32'h0);
    wr(`MCT_CTRL_OFS, 32'h1);
    do rdr(`MCT_CTRL_OFS); while (rd[0] === 1'b1);
    rdr(`MCT_COUNT_OFS);
    chk("stopped count", 32'h3, rd);
    chk("high pins", 32'h0c, 32'(match_pin));
    chk("masked irq", 32'h0, 32'(irq));
    rdr(`MCT_INT_STS_OFS);
    chk("masked flag", 32'h2, rd);
    wr(`MCT_PIN_SEL_OFS, 32'h0000_0249);
    @(posedge core_clk);
    chk("pins disabled", 32'h0, 32'(match_pin));
  endtask

  task automatic t_event_capture;
    wr(`MCT_MATCH_CTL_OFS, 32'h0);
    wr(`MCT_COUNT_OFS, 32'h0);
    wr(`MCT_CAP_CTL_OFS, 32'h28);
    wr(`MCT_INT_MASK_OFS, 32'h20);
    wr(`MCT_CTRL_OFS, 32'h5);
    repeat (3) pulse(0);
    pulse(2);
    while (!irq) @(posedge core_clk);
    rdr(`MCT_COUNT_OFS);
    chk("event count", 32'h3, rd);
    rdr(`MCT_CAP0_OFS + 8'h04);
    chk("capture1", 32'h3, rd);
    rdr(`MCT_CAP0_OFS);
    chk("capture0 idle", 32'h0, rd);
    rdr(`MCT_INT_STS_OFS);
    chk("capture flag", 32'h20, rd);
  endtask

  task automatic pair_pulse;
    want <= 8'h03;
    repeat (2) @(posedge core_clk);
    want <= 8'h00;
    repeat (4) @(posedge core_clk);
  endtask

  // AND combine, falling and both-edge counting, counter hold and a low action
  task automatic t_modes;
    wr(`MCT_CTRL_OFS, 32'h2);
    rdr(`MCT_COUNT_OFS);
    chk("held in reset", 32'h0, rd);
    wr(`MCT_PIN_SEL_OFS, 32'h00ff_024f);
    wr(`MCT_MATCH0_OFS + 8'h04, 32'h2);
    wr(`MCT_EXT_MATCH_OFS, 32'h42);
    wr(`MCT_CTRL_OFS, 32'h9);
    chk("preset pins", 32'h0c, 32'(match_pin));
    pulse(0);
    repeat (2) @(posedge core_clk);
    pair_pulse();
    wr(`MCT_CTRL_OFS, 32'hd);
    pair_pulse();
    rdr(`MCT_COUNT_OFS);
    chk("and edges count", 32'h3, rd);
    chk("low pins", 32'h0, 32'(match_pin));
  endtask

  task automatic t_narrow;
    wr(`MCT_CTRL_OFS, 32'h0);
    wr(`MCT_PRE_LIM_OFS, 32'h1234_5678);
    rdr(`MCT_PRE_LIM_OFS);
    chk("wide prescale", 32'h1234_5678, rd);
    chk("narrow prescale", 32'h0000_5678, rd_n);
    wr(`MCT_COUNT_OFS, 32'hffff_ffff);
    rdr(`MCT_COUNT_OFS);
    chk("wide count", 32'hffff_ffff, rd);
    chk("narrow count", 32'h0000_ffff, rd_n);
    wr(`MCT_MATCH0_OFS + 8'h08, 32'habcd_1234);
    rdr(`MCT_MATCH0_OFS + 8'h08);
    chk("wide match2", 32'habcd_1234, rd);
    chk("narrow match2", 32'h0000_1234, rd_n);
    wr(`MCT_CAP_CTL_OFS, 32'h240);
    pulse(4);
    pulse(6);
    rdr(`MCT_CAP0_OFS + 8'h08);
    chk("narrow capture2", 32'h0000_ffff, rd_n);
    rdr(`MCT_CAP0_OFS + 8'h0c);
    chk("wide capture3", 32'hffff_ffff, rd);
    chk("narrow capture3", 32'h0, rd_n);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    close_out();
  end

  initial begin
    rstn = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    want = 8'h00;
    // A clean falling edge after time zero reaches every reset flop
    #10;
    rstn = 1'b0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_reset_values();
    t_reset_on_match();
    t_stop_on_match();
    t_event_capture();
    t_modes();
    t_narrow();
    close_out();
  end
endmodule
